/* File: logic/smr_pkg.sv */
package smr_pkg;

    // Special-function register addresses
    localparam logic [7:0] SUPPLY_CTRL_ADDR = 8'hFF;
    localparam logic [7:0] RESET_CAUSE_ADDR = 8'hEF;

    // Supply monitor control fields
    localparam int CTL_DIG_EN   = 7;
    localparam int CTL_DIG_STAT = 6;
    localparam int CTL_DIG_WARN = 5;
    localparam int CTL_DIG_IE   = 4;
    localparam int CTL_BAT_EN   = 3;
    localparam int CTL_BAT_STAT = 2;
    localparam int CTL_BAT_WARN = 1;
    localparam int CTL_BAT_IE   = 0;

    // Monitor index and per-monitor field offset from bit 0
    localparam int MON_DIG      = 1;
    localparam int MON_BAT      = 0;
    localparam int MON_FIELD_W  = 4;
    localparam int FLD_EN       = 3;
    localparam int FLD_STAT     = 2;
    localparam int FLD_WARN     = 1;
    localparam int FLD_IE       = 0;

    // Reset cause fields
    localparam int CAUSE_PIN    = 0;
    localparam int CAUSE_PWR    = 1;
    localparam int CAUSE_CLK    = 2;
    localparam int CAUSE_CMP    = 5;
    localparam int CAUSE_FLASH  = 6;

    // Reset values
    localparam logic [1:0] MON_EN_RST  = 2'h2;
    localparam logic [1:0] MON_IE_RST  = 2'h0;
    localparam logic       PWR_SEL_RST = 1'b1;
    localparam logic       CLK_EN_RST  = 1'b0;
    localparam logic       CMP_EN_RST  = 1'b0;
    localparam logic [7:0] RDATA_RST   = 8'h00;

    // Internal reset request vector
    localparam int REQ_SUPPLY   = 0;
    localparam int REQ_PIN      = 1;
    localparam int REQ_CLK      = 2;
    localparam int REQ_CMP      = 3;
    localparam int REQ_FLASH    = 4;
    localparam int REQ_POR      = 5;
    localparam int REQ_W        = 6;
    localparam logic [REQ_W-1:0] PEND_RST = 6'h20;

    // Timing
    localparam int CLK_PERIOD_NS       = 25;
    localparam int CLK_LOSS_TIMEOUT_NS = 100000;
    localparam int CLK_LOSS_CYCLES     = (CLK_LOSS_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLK_LOSS_W          = 13;
    localparam int HOLD_CYCLES         = 8;
    localparam int HOLD_W              = 4;

    typedef enum logic {
        SMR_RUN,
        SMR_HELD
    } smr_state_t;

endpackage

/* File: logic/smr_reset_sources.sv */
`timescale 1ns/100ps
module smr_reset_sources (
    input  wire logic       ref_clk_in,
    input  wire logic       rst_in,
    input  wire logic [7:0] sfr_addr_in,
    input  wire logic       sfr_wr_in,
    input  wire logic       sfr_rd_in,
    input  wire logic [7:0] sfr_wdata_in,
    output logic      [7:0] sfr_rdata_out,
    input  wire logic       digital_above_reset_in,
    input  wire logic       digital_above_warn_in,
    input  wire logic       battery_above_reset_in,
    input  wire logic       battery_above_warn_in,
    input  wire logic       ext_reset_n_in,
    output logic            reset_pin_out,
    output logic            reset_pin_oe_n_out,
    input  wire logic       sys_clk_level_in,
    input  wire logic       comparator_noninverting_below_in,
    input  wire logic       comparator_wake_enable_in,
    input  wire logic       sleep_mode_in,
    input  wire logic       suspend_mode_in,
    input  wire logic       flash_op_req_in,
    output logic            flash_op_grant_out,
    output logic            core_reset_out,
    output logic            ram_invalid_out,
    output logic            digital_warning_irq_out,
    output logic            battery_warning_irq_out
);

    smr_pkg::smr_state_t           state_reg;
    logic [smr_pkg::REQ_W-1:0]     pend_reg;
    logic [smr_pkg::REQ_W-1:0]     req;
    logic [1:0]                    mon_en_reg;
    logic [1:0]                    mon_ie_reg;
    logic [1:0]                    mon_stat_reg;
    logic [1:0]                    mon_warn_reg;
    logic [1:0]                    irq_reg;
    logic [1:0]                    above_reset;
    logic [1:0]                    above_warn;
    logic                          pwr_sel_reg;
    logic                          clk_en_reg;
    logic                          cmp_en_reg;
    logic                          pin_flag_reg;
    logic                          pwr_flag_reg;
    logic                          clk_flag_reg;
    logic                          cmp_flag_reg;
    logic                          flash_flag_reg;
    logic                          core_reset_reg;
    logic                          pin_oe_n_reg;
    logic                          ram_invalid_reg;
    logic                          grant_reg;
    logic [7:0]                    rdata_reg;
    logic                          clk_prev_reg;
    logic                          low_power;
    logic                          supply_low;
    logic                          clk_loss_run;
    logic                          clk_loss_expired;
    logic                          hold_expired;
    logic                          level_active;
    logic                          release_now;
    logic                          power_cause;
    logic                          wr_ctrl;
    logic                          wr_cause;
    logic [7:0]                    ctrl_view;
    logic [7:0]                    cause_view;

    assign low_power = sleep_mode_in || suspend_mode_in;
    assign above_reset = {digital_above_reset_in, battery_above_reset_in};
    assign above_warn  = {digital_above_warn_in, battery_above_warn_in};
    assign wr_ctrl  = sfr_wr_in && !core_reset_reg && (sfr_addr_in == smr_pkg::SUPPLY_CTRL_ADDR);
    assign wr_cause = sfr_wr_in && !core_reset_reg && (sfr_addr_in == smr_pkg::RESET_CAUSE_ADDR);

    // Per-monitor status, warning and interrupt
    genvar m;
    generate
        for (m = 0; m < 2; m++) begin : g_mon
            always_ff @(posedge ref_clk_in) begin
                if (rst_in) begin
                    mon_stat_reg[m] <= 1'b0;
                    mon_warn_reg[m] <= 1'b0;
                    irq_reg[m]      <= 1'b0;
                end else begin
                    mon_stat_reg[m] <= above_reset[m];
                    mon_warn_reg[m] <= above_warn[m];
                    irq_reg[m]      <= mon_ie_reg[m] && mon_en_reg[m] && !above_warn[m]
                                       && !sleep_mode_in;
                end
            end
        end
    endgenerate

    assign supply_low = pwr_sel_reg && mon_en_reg[smr_pkg::MON_DIG]
                        && !digital_above_reset_in && !sleep_mode_in;

    assign clk_loss_run = clk_en_reg && !low_power && (sys_clk_level_in == clk_prev_reg);

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            clk_prev_reg <= 1'b0;
        end else begin
            clk_prev_reg <= sys_clk_level_in;
        end
    end

    smr_timer #(
        .WIDTH       (smr_pkg::CLK_LOSS_W),
        .LIMIT       (smr_pkg::CLK_LOSS_W'(smr_pkg::CLK_LOSS_CYCLES))
    ) u_clk_loss (
        .ref_clk_in  (ref_clk_in),
        .rst_in      (rst_in),
        .run_in      (clk_loss_run),
        .expired_out (clk_loss_expired)
    );

    smr_timer #(
        .WIDTH       (smr_pkg::HOLD_W),
        .LIMIT       (smr_pkg::HOLD_W'(smr_pkg::HOLD_CYCLES))
    ) u_hold (
        .ref_clk_in  (ref_clk_in),
        .rst_in      (rst_in),
        .run_in      (state_reg == smr_pkg::SMR_HELD),
        .expired_out (hold_expired)
    );

    always_comb begin
        req = '0;
        req[smr_pkg::REQ_SUPPLY] = supply_low;
        // Pin reset in every mode
        // Pin low from own drive is not a request
        req[smr_pkg::REQ_PIN]    = !ext_reset_n_in && pin_oe_n_reg;
        req[smr_pkg::REQ_CLK]    = clk_loss_expired;
        req[smr_pkg::REQ_CMP]    = cmp_en_reg && comparator_noninverting_below_in
                                   && (!low_power || comparator_wake_enable_in);
        req[smr_pkg::REQ_FLASH]  = flash_op_req_in && !core_reset_reg
                                   && !mon_en_reg[smr_pkg::MON_DIG];
    end

    assign level_active = req[smr_pkg::REQ_SUPPLY] || req[smr_pkg::REQ_PIN]
                          || req[smr_pkg::REQ_CLK] || req[smr_pkg::REQ_CMP];
    assign release_now  = (state_reg == smr_pkg::SMR_HELD) && hold_expired && !level_active;
    assign power_cause  = pend_reg[smr_pkg::REQ_SUPPLY] || pend_reg[smr_pkg::REQ_POR];

    // Reset sequencing
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_reg      <= smr_pkg::SMR_HELD;
            pend_reg       <= smr_pkg::PEND_RST;
            core_reset_reg <= 1'b1;
        end else begin
            case (state_reg)
                smr_pkg::SMR_RUN: begin
                    if (|req) begin
                        state_reg      <= smr_pkg::SMR_HELD;
                        pend_reg       <= req;
                        core_reset_reg <= 1'b1;
                    end
                end
                smr_pkg::SMR_HELD: begin
                    if (release_now) begin
                        state_reg      <= smr_pkg::SMR_RUN;
                        pend_reg       <= '0;
                        core_reset_reg <= 1'b0;
                    end else begin
                        pend_reg       <= pend_reg | req;
                    end
                end
                default: begin
                    state_reg      <= smr_pkg::SMR_HELD;
                    pend_reg       <= smr_pkg::PEND_RST;
                    core_reset_reg <= 1'b1;
                end
            endcase
        end
    end

    // Pin driven low for power resets
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            pin_oe_n_reg <= 1'b0;
        end else if (state_reg == smr_pkg::SMR_HELD && !release_now) begin
            pin_oe_n_reg <= !(power_cause || req[smr_pkg::REQ_SUPPLY]);
        end else if (state_reg == smr_pkg::SMR_RUN && req[smr_pkg::REQ_SUPPLY]) begin
            pin_oe_n_reg <= 1'b0;
        end else begin
            pin_oe_n_reg <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            pin_flag_reg    <= 1'b0;
            pwr_flag_reg    <= 1'b0;
            clk_flag_reg    <= 1'b0;
            cmp_flag_reg    <= 1'b0;
            flash_flag_reg  <= 1'b0;
            ram_invalid_reg <= 1'b1;
        end else if (release_now) begin
            pwr_flag_reg    <= power_cause;
            ram_invalid_reg <= power_cause;
            pin_flag_reg    <= !power_cause && pend_reg[smr_pkg::REQ_PIN];
            clk_flag_reg    <= !power_cause && pend_reg[smr_pkg::REQ_CLK];
            cmp_flag_reg    <= !power_cause && pend_reg[smr_pkg::REQ_CMP];
            flash_flag_reg  <= !power_cause && pend_reg[smr_pkg::REQ_FLASH];
        end
    end

    // Monitor enable and select state
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            mon_en_reg  <= smr_pkg::MON_EN_RST;
            pwr_sel_reg <= smr_pkg::PWR_SEL_RST;
        end else if (release_now && power_cause) begin
            mon_en_reg  <= smr_pkg::MON_EN_RST;
            pwr_sel_reg <= smr_pkg::PWR_SEL_RST;
        end else begin
            if (wr_ctrl) begin
                mon_en_reg[smr_pkg::MON_DIG] <= sfr_wdata_in[smr_pkg::CTL_DIG_EN];
                mon_en_reg[smr_pkg::MON_BAT] <= sfr_wdata_in[smr_pkg::CTL_BAT_EN];
            end
            if (wr_cause) begin
                pwr_sel_reg <= sfr_wdata_in[smr_pkg::CAUSE_PWR];
            end
        end
    end

    // Interrupt enables clear on any reset
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || core_reset_reg) begin
            mon_ie_reg <= smr_pkg::MON_IE_RST;
        end else if (wr_ctrl) begin
            mon_ie_reg[smr_pkg::MON_DIG] <= sfr_wdata_in[smr_pkg::CTL_DIG_IE];
            mon_ie_reg[smr_pkg::MON_BAT] <= sfr_wdata_in[smr_pkg::CTL_BAT_IE];
        end
    end

    // Clock-loss and comparator enables
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            clk_en_reg <= smr_pkg::CLK_EN_RST;
            cmp_en_reg <= smr_pkg::CMP_EN_RST;
        end else if (wr_cause) begin
            clk_en_reg <= sfr_wdata_in[smr_pkg::CAUSE_CLK];
            cmp_en_reg <= sfr_wdata_in[smr_pkg::CAUSE_CMP];
        end
    end

    // Flash operation gate
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            grant_reg <= 1'b0;
        end else begin
            grant_reg <= flash_op_req_in && !core_reset_reg && mon_en_reg[smr_pkg::MON_DIG];
        end
    end

    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[smr_pkg::CTL_DIG_EN]   = mon_en_reg[smr_pkg::MON_DIG];
        ctrl_view[smr_pkg::CTL_DIG_STAT] = mon_stat_reg[smr_pkg::MON_DIG];
        ctrl_view[smr_pkg::CTL_DIG_WARN] = mon_warn_reg[smr_pkg::MON_DIG];
        ctrl_view[smr_pkg::CTL_DIG_IE]   = mon_ie_reg[smr_pkg::MON_DIG];
        ctrl_view[smr_pkg::CTL_BAT_EN]   = mon_en_reg[smr_pkg::MON_BAT];
        ctrl_view[smr_pkg::CTL_BAT_STAT] = mon_stat_reg[smr_pkg::MON_BAT];
        ctrl_view[smr_pkg::CTL_BAT_WARN] = mon_warn_reg[smr_pkg::MON_BAT];
        ctrl_view[smr_pkg::CTL_BAT_IE]   = mon_ie_reg[smr_pkg::MON_BAT];
    end

    always_comb begin
        cause_view = 8'h00;
        cause_view[smr_pkg::CAUSE_PIN]   = pin_flag_reg;
        cause_view[smr_pkg::CAUSE_PWR]   = pwr_flag_reg;
        cause_view[smr_pkg::CAUSE_CLK]   = clk_flag_reg;
        cause_view[smr_pkg::CAUSE_CMP]   = cmp_flag_reg;
        cause_view[smr_pkg::CAUSE_FLASH] = flash_flag_reg;
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rdata_reg <= smr_pkg::RDATA_RST;
        end else if (sfr_rd_in && sfr_addr_in == smr_pkg::SUPPLY_CTRL_ADDR) begin
            rdata_reg <= ctrl_view;
        end else if (sfr_rd_in && sfr_addr_in == smr_pkg::RESET_CAUSE_ADDR) begin
            rdata_reg <= cause_view;
        end else if (sfr_rd_in) begin
            rdata_reg <= smr_pkg::RDATA_RST;
        end
    end

    assign sfr_rdata_out           = rdata_reg;
    assign reset_pin_out           = 1'b0;
    assign reset_pin_oe_n_out      = pin_oe_n_reg;
    assign flash_op_grant_out      = grant_reg;
    assign core_reset_out          = core_reset_reg;
    assign ram_invalid_out         = ram_invalid_reg;
    assign digital_warning_irq_out = irq_reg[smr_pkg::MON_DIG];
    assign battery_warning_irq_out = irq_reg[smr_pkg::MON_BAT];

endmodule

/* File: logic/smr_timer.sv */
`timescale 1ns/100ps
module smr_timer #(
    parameter int                WIDTH = 4,
    parameter logic [WIDTH-1:0]  LIMIT = 4'h8
) (
    input  wire logic ref_clk_in,
    input  wire logic rst_in,
    input  wire logic run_in,
    output logic      expired_out
);

    logic [WIDTH-1:0] cnt_reg;
    logic             expired_reg;

    // Count while running, restart when stopped
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || !run_in) begin
            cnt_reg <= '0;
        end else if (cnt_reg != LIMIT) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in || !run_in) begin
            expired_reg <= 1'b0;
        end else begin
            expired_reg <= (cnt_reg >= LIMIT - 1'b1);
        end
    end

    assign expired_out = expired_reg;

endmodule

/* File: test/smr_far_side.sv */
`timescale 1ns/100ps
module smr_far_side (
    input  wire logic ref_clk_in,
    input  wire logic press_in,
    input  wire logic stop_clk_in,
    input  wire logic reset_pin_in,
    input  wire logic reset_pin_oe_n_in,
    output logic      ext_reset_n_out,
    output logic      sys_clk_level_out
);
    // pulled-up pin, low when pressed or driven
    assign ext_reset_n_out = !press_in && (reset_pin_oe_n_in || reset_pin_in);

    initial sys_clk_level_out = 1'b0;
    always @(posedge ref_clk_in) begin
        if (!stop_clk_in) begin
            sys_clk_level_out <= !sys_clk_level_out;
        end
    end
endmodule

/* File: test/smr_reset_sources_chk.sv */
`timescale 1ns/100ps
module smr_reset_sources_chk (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic ext_reset_n_in,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe_n_out,
    input wire logic digital_above_reset_in,
    input wire logic digital_above_warn_in,
    input wire logic battery_above_warn_in,
    input wire logic sys_clk_level_in,
    input wire logic comparator_noninverting_below_in,
    input wire logic sleep_mode_in,
    input wire logic flash_op_req_in,
    input wire logic flash_op_grant_out,
    input wire logic core_reset_out,
    input wire logic ram_invalid_out,
    input wire logic digital_warning_irq_out,
    input wire logic battery_warning_irq_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    logic [4:0] quiet_cnt_reg;

    // Cycles held in reset with no level request pending
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || !core_reset_out || !ext_reset_n_in || !digital_above_reset_in
            || comparator_noninverting_below_in || !$changed(sys_clk_level_in)) begin
            quiet_cnt_reg <= 5'h00;
        end else if (quiet_cnt_reg != 5'h1F) begin
            quiet_cnt_reg <= quiet_cnt_reg + 5'h01;
        end
    end

    property p_pin_reset;
        !ext_reset_n_in && reset_pin_oe_n_out |=> core_reset_out;
    endproperty
    a_pin_reset: assert property (p_pin_reset)
        else $error("pin low without core reset");
    property p_pin_drive;
        !reset_pin_oe_n_out |-> core_reset_out && !reset_pin_out;
    endproperty
    a_pin_drive: assert property (p_pin_drive)
        else $error("pin driven outside core reset");
    property p_hold;
        $rose(core_reset_out) |-> core_reset_out [*8];
    endproperty
    a_hold: assert property (p_hold)
        else $error("core reset too short");
    property p_quick_release;
        quiet_cnt_reg <= 5'h0E;
    endproperty
    a_quick_release: assert property (p_quick_release)
        else $error("reset release delayed");
    property p_supply_release;
        $rose(reset_pin_oe_n_out) |-> ram_invalid_out && !core_reset_out;
    endproperty
    a_supply_release: assert property (p_supply_release)
        else $error("supply reset release wrong");
    property p_sleep_no_drive;
        sleep_mode_in && reset_pin_oe_n_out |=> reset_pin_oe_n_out;
    endproperty
    a_sleep_no_drive: assert property (p_sleep_no_drive)
        else $error("supply reset in sleep");
    property p_dig_irq;
        digital_warning_irq_out |-> !$past(digital_above_warn_in) && !$past(sleep_mode_in);
    endproperty
    a_dig_irq: assert property (p_dig_irq)
        else $error("digital warning irq without cause");
    property p_bat_irq;
        battery_warning_irq_out |-> !$past(battery_above_warn_in) && !$past(sleep_mode_in);
    endproperty
    a_bat_irq: assert property (p_bat_irq)
        else $error("battery warning irq without cause");
    property p_grant_cause;
        flash_op_grant_out |-> $past(flash_op_req_in);
    endproperty
    a_grant_cause: assert property (p_grant_cause)
        else $error("grant without request");
    property p_flash_answer;
        flash_op_req_in && !core_reset_out |=> flash_op_grant_out || core_reset_out;
    endproperty
    a_flash_answer: assert property (p_flash_answer)
        else $error("flash request unanswered");

    c_supply: cover property ($fell(reset_pin_oe_n_out));
    c_irq: cover property ($rose(battery_warning_irq_out));
    c_grant: cover property (flash_op_grant_out);
endmodule

bind smr_reset_sources smr_reset_sources_chk i_chk (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .ext_reset_n_in(ext_reset_n_in),
    .reset_pin_out(reset_pin_out), .reset_pin_oe_n_out(reset_pin_oe_n_out),
    .digital_above_reset_in(digital_above_reset_in),
    .digital_above_warn_in(digital_above_warn_in),
    .battery_above_warn_in(battery_above_warn_in), .sys_clk_level_in(sys_clk_level_in),
    .comparator_noninverting_below_in(comparator_noninverting_below_in),
    .sleep_mode_in(sleep_mode_in), .flash_op_req_in(flash_op_req_in),
    .flash_op_grant_out(flash_op_grant_out), .core_reset_out(core_reset_out),
    .ram_invalid_out(ram_invalid_out), .digital_warning_irq_out(digital_warning_irq_out),
    .battery_warning_irq_out(battery_warning_irq_out)
);

/* File: test/test_supply_monitor_reset_sources.sv */
`timescale 1ns/100ps
module test_supply_monitor_reset_sources;
    logic       clk, rst, wr, rd, press, stop_clk, cmp_below, cmp_wake;
    logic       dig_rst, dig_warn, bat_rst, bat_warn, sleep, susp, flash_req;
    logic       ext_n, pin, oe_n, sys_lvl, grant, core_rst, ram_inv, dig_irq, bat_irq;
    logic [7:0] addr, wdata, rdata, w;
    logic       rd_pend;
    logic [7:0] exp_q[$];
    int         fail_count, checks_done, seed;

    smr_reset_sources i_dut (
        .ref_clk_in(clk), .rst_in(rst), .sfr_addr_in(addr), .sfr_wr_in(wr),
        .sfr_rd_in(rd), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata),
        .digital_above_reset_in(dig_rst), .digital_above_warn_in(dig_warn),
        .battery_above_reset_in(bat_rst), .battery_above_warn_in(bat_warn),
        .ext_reset_n_in(ext_n), .reset_pin_out(pin), .reset_pin_oe_n_out(oe_n),
        .sys_clk_level_in(sys_lvl), .comparator_noninverting_below_in(cmp_below),
        .comparator_wake_enable_in(cmp_wake), .sleep_mode_in(sleep), .suspend_mode_in(susp),
        .flash_op_req_in(flash_req), .flash_op_grant_out(grant), .core_reset_out(core_rst),
        .ram_invalid_out(ram_inv), .digital_warning_irq_out(dig_irq),
        .battery_warning_irq_out(bat_irq)
    );
    smr_far_side i_far (
        .ref_clk_in(clk), .press_in(press), .stop_clk_in(stop_clk), .reset_pin_in(pin),
        .reset_pin_oe_n_in(oe_n), .ext_reset_n_out(ext_n), .sys_clk_level_out(sys_lvl)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        step(1);
        wr = 1'b0;
        step(1);
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
        addr = a;
        rd = 1'b1;
        exp_q.push_back(e);
        step(1);
        rd = 1'b0;
        step(1);
    endtask
    task automatic rc(input logic [7:0] e);
        reg_rd(smr_pkg::SUPPLY_CTRL_ADDR, e);
    endtask
    task automatic rs(input logic [7:0] e);
        reg_rd(smr_pkg::RESET_CAUSE_ADDR, e);
    endtask
    task automatic wait_rel();
        int n;
        n = 0;
        while (core_rst !== 1'b0 && n < 6000) begin
            step(1);
            n++;
        end
        check({7'h00, core_rst}, 8'h00);
    endtask
    task automatic print_verdict();
        if (fail_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Read data lands one edge after the strobe
    always @(negedge clk) begin
        if (rd_pend) begin
            check(rdata, exp_q.pop_front());
        end
        rd_pend = rd;
    end

    initial begin
        #(25 * 40000);
        fail_count++;
        print_verdict();
    end

    initial begin
        seed = 4;
        {rst, dig_rst, dig_warn, bat_rst, bat_warn} = 5'h1F;
        {wr, rd, press, stop_clk, cmp_below, cmp_wake, sleep, susp, flash_req} = 9'h000;
        {addr, wdata, rd_pend, fail_count, checks_done} = '0;
        step(5);
        rst = 1'b0;
        wait_rel();
        rc(8'hE6);
        rs(8'h02);
        reg_rd(8'h10, 8'h00);
        check({7'h00, ram_inv}, 8'h01);
        repeat (4) begin
            w = 8'($random(seed));
            reg_wr(smr_pkg::SUPPLY_CTRL_ADDR, w);
            rc((w & 8'h99) | 8'h66);
        end
        reg_wr(smr_pkg::SUPPLY_CTRL_ADDR, 8'h89);
        reg_wr(smr_pkg::RESET_CAUSE_ADDR, 8'h02);
        sleep = 1'b1;
        press = 1'b1;
        step(2);
        check({7'h00, core_rst}, 8'h01);
        press = 1'b0;
        sleep = 1'b0;
        wait_rel();
        rs(8'h01);
        rc(8'hEE);
        check({7'h00, ram_inv}, 8'h00);
        reg_wr(smr_pkg::SUPPLY_CTRL_ADDR, 8'h99);
        bat_warn = 1'b0;
        step(3);
        check({7'h00, bat_irq}, 8'h01);
        sleep = 1'b1;
        step(3);
        check({7'h00, bat_irq}, 8'h00);
        sleep = 1'b0;
        step(3);
        rc(8'hFD);
        bat_warn = 1'b1;
        dig_warn = 1'b0;
        step(3);
        check({6'h00, dig_irq, bat_irq}, 8'h02);
        dig_warn = 1'b1;
        sleep = 1'b1;
        dig_rst = 1'b0;
        step(4);
        check({7'h00, core_rst}, 8'h00);
        dig_rst = 1'b1;
        step(1);
        sleep = 1'b0;
        dig_rst = 1'b0;
        step(2);
        check({6'h00, core_rst, oe_n}, 8'h02);
        dig_rst = 1'b1;
        wait_rel();
        rs(8'h02);
        rc(8'hE6);
        check({7'h00, ram_inv}, 8'h01);
        flash_req = 1'b1;
        step(1);
        check({7'h00, grant}, 8'h01);
        flash_req = 1'b0;
        reg_wr(smr_pkg::SUPPLY_CTRL_ADDR, 8'h00);
        flash_req = 1'b1;
        step(1);
        flash_req = 1'b0;
        step(1);
        check({6'h00, core_rst, grant}, 8'h02);
        wait_rel();
        rs(8'h40);
        rc(8'h66);
        reg_wr(smr_pkg::SUPPLY_CTRL_ADDR, 8'h80);
        reg_wr(smr_pkg::RESET_CAUSE_ADDR, 8'h22);
        sleep = 1'b1;
        cmp_below = 1'b1;
        step(4);
        check({7'h00, core_rst}, 8'h00);
        cmp_wake = 1'b1;
        step(2);
        check({7'h00, core_rst}, 8'h01);
        {sleep, cmp_wake, cmp_below} = 3'h0;
        wait_rel();
        rs(8'h20);
        reg_wr(smr_pkg::RESET_CAUSE_ADDR, 8'h06);
        susp = 1'b1;
        stop_clk = 1'b1;
        step(4100);
        check({7'h00, core_rst}, 8'h00);
        susp = 1'b0;
        stop_clk = 1'b0;
        step(2);
        stop_clk = 1'b1;
        step(3990);
        check({7'h00, core_rst}, 8'h00);
        step(20);
        check({7'h00, core_rst}, 8'h01);
        stop_clk = 1'b0;
        wait_rel();
        rs(8'h04);
        reg_wr(smr_pkg::RESET_CAUSE_ADDR, 8'h02);
        step(3);
        print_verdict();
    end
endmodule
